// *** dv/flash_cmd_host_props.sv ***
/*
  checker for the flash pins and register read port of flash_cmd_host.
  assumes the strobe lengths set down in flash_host_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_props
  import flash_host_pkg::*;
(
  // clock, reset, register port
  input wire logic               clk_i,
  input wire logic               srst_i,
  input wire logic               reg_re_i,
  input wire logic [31:0]        reg_rdata_o,
  // flash pins
  input wire logic [FDATA_W-1:0] dq_o,
  input wire logic               dq_oe_o,
  input wire logic [FADDR_W-1:0] addr_o,
  input wire logic               flash_select_n_o,
  input wire logic               write_n_o,
  input wire logic               read_n_o
);
  // ------
  // assertions
  // ------
  default clocking @(posedge clk_i); endclocking
  a_rdata_idle_zero: assert property (disable iff (srst_i)
    !$past(reg_re_i) |-> reg_rdata_o == 32'h0) else $error("read data outside its cycle");
  a_strobe_excl: assert property (disable iff (srst_i) !(!write_n_o && !read_n_o))
    else $error("read and write strobes both low");
  a_write_selects: assert property (disable iff (srst_i) !write_n_o |-> !flash_select_n_o)
    else $error("write without select");
  a_write_len: assert property (disable iff (srst_i)
    $fell(write_n_o) |-> (!write_n_o && dq_oe_o)[*3] ##1 write_n_o) else $error("write strobe length");
  a_read_len: assert property (disable iff (srst_i)
    $fell(read_n_o) |-> (!read_n_o && !dq_oe_o)[*6] ##1 read_n_o) else $error("read strobe length");
  a_data_hold: assert property (disable iff (srst_i)
    $rose(write_n_o) && !$past(srst_i) |-> dq_oe_o && $stable(dq_o)) else $error("data not held");
  a_addr_steady: assert property (disable iff (srst_i)
    !write_n_o && $past(!write_n_o) |-> $stable(addr_o) && $stable(dq_o)) else $error("addr moved");
  a_reset_idle: assert property (srst_i |=> write_n_o && read_n_o && flash_select_n_o && !dq_oe_o)
    else $error("pins active in reset");
endmodule
bind flash_cmd_host flash_cmd_host_props u_props (.clk_i(clk_i), .srst_i(srst_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .addr_o(addr_o), .flash_select_n_o(flash_select_n_o), .write_n_o(write_n_o),
  .read_n_o(read_n_o));
`default_nettype wire

// *** dv/flash_cmd_host_tb_top.sv ***
/*
  testbench for flash_cmd_host against the behavioural flash device.
  assumes the register map and opcodes of flash_host_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_tb_top;
  import flash_host_pkg::*;
  // ------
  // dut, device and clock
  // ------
  logic              clk_i = 1'b0, srst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0, acc_seen = 1'b0;
  logic [REG_AW-1:0] reg_addr_i = 3'h0;
  logic [31:0]       reg_wdata_i = 32'h0, reg_rdata_o, s;
  logic [15:0]       dq_o, m_dq, bus;
  logic [22:0]       addr_o;
  logic              dq_oe_o, sel_n, we_n, re_n, rb_n, accel;
  int                n_mismatch = 0, checks = 0, p = 0, cyc = 0;
  assign bus = dq_oe_o ? dq_o : m_dq;
  flash_cmd_host u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .addr_o(addr_o), .flash_select_n_o(sel_n),
    .write_n_o(we_n), .read_n_o(re_n), .ready_busy_n_i(rb_n), .accel_req_o(accel));
  flash_dev_model u_dev (.sel_n_i(sel_n), .we_n_i(we_n), .re_n_i(re_n), .addr_i(addr_o),
    .dq_i(bus), .accel_i(accel), .dq_o(m_dq), .ready_busy_n_o(rb_n));
  initial forever #50 clk_i = ~clk_i;
  // hang guard, well above the longest erase
  always @(posedge clk_i) begin
    cyc++;
    if (accel) acc_seen = 1'b1;
    if (cyc == 40000) begin n_mismatch++; final_report(); end
  end
  // ------
  // register access and checks
  // ------
  task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic wr(logic [REG_AW-1:0] a, logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(logic [REG_AW-1:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 s = reg_rdata_o;
  endtask
  task automatic waitst(int b, logic v);
    for (int i = 0; i < 3000; i++) begin rd(REG_STATUS); if (s[b] === v) return; end
    chk("status wait", s[b], v);
  endtask
  task automatic op(logic [3:0] o, logic [22:0] a, logic [15:0] d);
    wr(REG_ADDR, {9'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {28'h0, o});
  endtask
  task automatic ex(logic [22:0] a, logic [15:0] d);
    chk("flash addr", u_dev.log_a[p], a);
    chk("flash data", u_dev.log_d[p], d);
    p++;
  endtask
  task automatic unl();
    ex(UNLOCK_ADDR1, UNLOCK_DATA1);
    ex(UNLOCK_ADDR2, UNLOCK_DATA2);
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------
  // sequence
  // ------
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(REG_STATUS);
    chk("status", s, 32'h0);
    rd(3'h7);
    chk("unmapped", s, 32'h0);
    // program, a refused job meanwhile, then try to raise zeros
    op(OP_PROGRAM, 23'h012345, 16'h1234);
    wr(REG_CMD, {28'h0, OP_SEC_ENTER});
    rd(REG_STATUS);
    chk("refused", s[ST_REFUSED], 1'b1);
    waitst(ST_BUSY, 1'b0);
    unl();
    ex(UNLOCK_ADDR1, CMD_PROGRAM);
    ex(23'h012345, 16'h1234);
    op(OP_PROGRAM, 23'h012345, 16'hffff);
    waitst(ST_BUSY, 1'b0);
    p = p + 3;
    ex(23'h012345, 16'hffff);
    op(OP_READ, 23'h012345, 16'h0);
    waitst(ST_BUSY, 1'b0);
    rd(REG_RDATA);
    chk("read back", s, 32'h1234);
    // chip erase
    op(OP_CHIP_ER, 23'h0, 16'h0);
    waitst(ST_DEV_BSY, 1'b1);
    waitst(ST_BUSY, 1'b0);
    unl();
    ex(UNLOCK_ADDR1, CMD_ERASE);
    unl();
    ex(UNLOCK_ADDR1, CMD_CHIP_ER);
    op(OP_READ, 23'h012345, 16'h0);
    waitst(ST_BUSY, 1'b0);
    rd(REG_RDATA);
    chk("erased", s, 32'hffff);
    // two sectors in one window, then a window cut short
    for (int k = 0; k < 2; k++) begin
      op(OP_SECT_ER, 23'h200000, 16'h0);
      waitst(ST_WIN_OPEN, 1'b1);
      op(k ? OP_READ : OP_SECT_ADD, 23'h100000, 16'h0);
      waitst(ST_DEV_BSY, 1'b0);
      waitst(ST_BUSY, 1'b0);
      p = p + 5;
      ex(23'h200000, CMD_SECT_ER);
      if (k == 0) ex(23'h100000, CMD_SECT_ER);
    end
    chk("no write", u_dev.log_a.size(), p);
    // secured region
    op(OP_SEC_ENTER, 23'h0, 16'h0);
    waitst(ST_SECURE, 1'b1);
    unl();
    ex(UNLOCK_ADDR1, CMD_SEC_IN);
    wr(REG_CMD, {28'h0, OP_BYP_ENTER});
    rd(REG_STATUS);
    chk("refused", s[ST_REFUSED], 1'b1);
    op(OP_SEC_EXIT, 23'h0, 16'h0);
    waitst(ST_SECURE, 1'b0);
    p = p + 3;
    chk("flash data", u_dev.log_d[p++], CMD_SEC_OUT2);
    // bypass mode, one program, exit, then reset
    op(OP_BYP_ENTER, 23'h0, 16'h0);
    waitst(ST_BYPASS, 1'b1);
    p = p + 2;
    ex(UNLOCK_ADDR1, CMD_BYPASS);
    op(OP_PROGRAM, 23'h040000, 16'h00a5);
    waitst(ST_BUSY, 1'b0);
    ex(UNLOCK_ADDR1, CMD_PROGRAM);
    ex(23'h040000, 16'h00a5);
    chk("accel", acc_seen, 1'b1);
    op(OP_BYP_EXIT, 23'h0, 16'h0);
    waitst(ST_BYPASS, 1'b0);
    ex(UNLOCK_ADDR1, CMD_BYP_RST);
    ex(UNLOCK_ADDR1, CMD_BYP_RST2);
    op(OP_RESET, 23'h0, 16'h0);
    waitst(ST_BUSY, 1'b0);
    ex(UNLOCK_ADDR1, CMD_RESET);
    final_report();
  end
endmodule
`default_nettype wire

// *** dv/flash_dev_model.sv ***
/*
  behavioural flash device: command decoder, self-timed busy, status reads.
  assumes a single bank in use and pins straight from the host.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
(
  // host pins
  input  wire logic               sel_n_i,
  input  wire logic               we_n_i,
  input  wire logic               re_n_i,
  input  wire logic [FADDR_W-1:0] addr_i,
  input  wire logic [FDATA_W-1:0] dq_i,
  input  wire logic               accel_i,
  // device outputs
  output logic [FDATA_W-1:0]      dq_o = 16'h0,
  output logic                    ready_busy_n_o = 1'b1
);
  // ------
  // command decoder
  // ------
  logic [FADDR_W-1:0] log_a[$], al;
  logic [FDATA_W-1:0] log_d[$], mem[logic [FADDR_W-1:0]];
  int st = 0;
  bit sec = 0, byp = 0, busy = 0, tog = 0;
  realtime wt;
  // self-timed algorithm; host gives no timing
  task automatic run(int ns);
    busy = 1;
    ready_busy_n_o = 0;
    fork begin #(ns); busy = 0; ready_busy_n_o = 1; end join_none
  endtask
  always @(negedge we_n_i) al = addr_i;
  always @(posedge we_n_i) if (!sel_n_i) begin
    log_a.push_back(al);
    log_d.push_back(dq_i);
    if (!busy) step(al, dq_i);
  end
  task automatic step(logic [FADDR_W-1:0] a, logic [FDATA_W-1:0] d);
    if (accel_i) byp = !sec;
    if (st == 6 && d != CMD_SECT_ER) begin st = 0; ready_busy_n_o = 1; end
    else if (d == CMD_RESET) st = 0;
    else case (st)
      0: st = byp ? (d == CMD_PROGRAM ? 7 : d == CMD_BYP_RST ? 8 : 0) : d == UNLOCK_DATA1;
      1: st = d == UNLOCK_DATA2 ? 2 : 0;
      2: begin
        st = d == CMD_PROGRAM ? 7 : d == CMD_ERASE ? 3 : d == CMD_SEC_OUT && sec ? 9 : 0;
        if (d == CMD_SEC_IN) sec = 1;
        if (d == CMD_BYPASS) byp = !sec;
      end
      3: st = d == UNLOCK_DATA1 ? 4 : 0;
      4: st = d == UNLOCK_DATA2 ? 5 : 0;
      5, 6: if (d == CMD_CHIP_ER && st == 5) begin mem.delete(); st = 0; run(100000); end
        else if (d == CMD_SECT_ER) begin st = 6; wt = $realtime; ready_busy_n_o = 0; end
        else st = 0;
      // zeros cannot be raised back to ones
      7: begin mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & d; st = 0; run(20000); end
      8: begin if (d == CMD_BYP_RST2) byp = 0; st = 0; end
      default: begin if (d == CMD_SEC_OUT2) sec = 0; st = 0; end
    endcase
  endtask
  // window expiry starts the erase
  always #1000 if (st == 6 && $realtime - wt >= 50000) begin st = 0; run(100000); end
  // status while busy or in the window, else array or secured words
  always @(negedge re_n_i) #20 if (!sel_n_i) begin
    tog = !tog;
    dq_o = busy || st == 6 ? {9'h0, tog, 2'h0, busy, tog, 2'h0}
      : sec ? 16'h5e5e : mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
  end
  // released bus never holds a stale value
  always @(posedge re_n_i) dq_o = ~dq_o;
endmodule
`default_nettype wire

// *** src/flash_bus_cycle.sv ***
/*
  one asynchronous flash bus cycle (write or read) with a timed strobe.
  assumes clk_i at 10 MHz; pins are driven from flip-flops only.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire  logic               clk_i,
  input  wire  logic               srst_i,
  input  wire  logic               ce_i,
  // request
  input  wire  logic               start_i,
  input  wire  logic               write_i,
  input  wire  logic [FADDR_W-1:0] addr_i,
  input  wire  logic [FDATA_W-1:0] data_i,
  output logic                     done_o,
  output logic [FDATA_W-1:0]       rdata_o,
  // flash pins
  input  wire  logic [FDATA_W-1:0] dq_i,
  output logic [FDATA_W-1:0]       dq_o,
  output logic                     dq_oe_o,
  output logic [FADDR_W-1:0]       addr_o,
  output logic                     flash_select_n_o,
  output logic                     write_n_o,
  output logic                     read_n_o
);

  logic [CNT_W-1:0]   cnt_q;
  logic               act_q;
  logic               setup_q;
  logic [FDATA_W-1:0] dq_m_q;
  logic [FDATA_W-1:0] dq_s_q;

  // ------
  // pin input synchroniser
  // ------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end else if (ce_i) begin
      dq_m_q <= dq_i;
      dq_s_q <= dq_m_q;
    end
  end

  // select and address lead the strobe fall by a cycle and select trails its rise,
  // so the device never latches a moving address or loses the closing edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      act_q            <= 1'b0;
      setup_q          <= 1'b0;
      cnt_q            <= '0;
      done_o           <= 1'b0;
      rdata_o          <= 16'h0000;
      dq_o             <= 16'h0000;
      dq_oe_o          <= 1'b0;
      addr_o           <= '0;
      flash_select_n_o <= 1'b1;
      write_n_o        <= 1'b1;
      read_n_o         <= 1'b1;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i && !act_q) begin
        act_q            <= 1'b1;
        setup_q          <= 1'b1;
        addr_o           <= addr_i;
        dq_o             <= data_i;
        dq_oe_o          <= write_i;
        flash_select_n_o <= 1'b0;
        cnt_q            <= write_i ? CNT_W'(STROBE_CYC) : CNT_W'(READ_CYC + 2);
      end else if (setup_q) begin
        setup_q   <= 1'b0;
        write_n_o <= !dq_oe_o;  // R23
        read_n_o  <= dq_oe_o;
      end else if (act_q) begin
        if (cnt_q == '0) begin
          // device takes data on this rise; dq and select still held
          act_q     <= 1'b0;
          done_o    <= 1'b1;
          rdata_o   <= dq_s_q;
          write_n_o <= 1'b1;
          read_n_o  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end else begin
        dq_oe_o          <= 1'b0;  // release a cycle after the strobe rises
        flash_select_n_o <= 1'b1;  // R23
      end
    end
  end

endmodule
`default_nettype wire

// *** src/flash_cmd_host.sv ***
/*
  host controller issuing command sequences to a multi-bank nor flash.
  assumes software on a plain register port; the flash ready/busy pin and
  data bus are asynchronous and are synchronised here.
*/
// Design decisions made here: the strobed register port and the placing of the registers.
// Contract
// R1: secured region entered by three writes, left by four writes.
// R2: no secured-region access while the device runs program or erase.
// R3: no bypass or accelerated programming while secured region enabled.
// R4: word program is two unlocks, set-up, then address and data.
// R5: device times program pulses itself; host only waits for ready.
// R6: commands during program are ignored; reset aborts, host repeats.
// R7: any address order allowed; zero-to-one fails, error bit may rise.
// R8: bypass entry is two unlocks then command 20h.
// R9: bypass program is A0h then address and data per word.
// R10: in bypass only bypass program and two-cycle bypass reset allowed.
// R11: high voltage on protect pin forces bypass mode automatically.
// R12: chip erase is six writes ending with chip erase command.
// R13: no host preprogramming or timing needed for erase.
// R14: erase progress shows on status bits and ready/busy output.
// R15: commands during chip erase ignored; reset aborts, host repeats.
// R16: sector erase is six writes ending with sector address and command.
// R17: further sectors added inside 50 us window, each gap under 50 us.
// R18: other commands during window return bank to read mode.
// R19: window timer starts at last strobe rise; erase-window bit shows expiry.
// R20: reads of non-erasing banks stay served during erase; host refuses every job, reads too, while ready/busy is low, except in the sector-erase window.
// R21: after sector erase starts only suspend accepted.
// R22: reset command returns banks to read mode, address ignored.
// R23: address taken on later falling edge, data on earlier rising edge.
// R24: host waits on status or ready/busy before a new operation.
// R25: command progress is tracked per bank; host keeps one sequence state for the whole device.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire  logic               clk_i,
  input  wire  logic               srst_i,
  input  wire  logic               ce_i,
  // register port
  input  wire  logic [REG_AW-1:0]  reg_addr_i,
  input  wire  logic [31:0]        reg_wdata_i,
  input  wire  logic               reg_we_i,
  input  wire  logic               reg_re_i,
  output logic [31:0]              reg_rdata_o,
  // flash pins
  input  wire  logic [FDATA_W-1:0] dq_i,
  output logic [FDATA_W-1:0]       dq_o,
  output logic                     dq_oe_o,
  output logic [FADDR_W-1:0]       addr_o,
  output logic                     flash_select_n_o,
  output logic                     write_n_o,
  output logic                     read_n_o,
  input  wire  logic               ready_busy_n_i,
  output logic                     accel_req_o
);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SEQ  = 5'b00010,
    S_WAIT = 5'b00100,
    S_WIN  = 5'b01000,
    S_POLL = 5'b10000
  } state_t;

  state_t             state_q;
  logic [3:0]         op_q;
  logic [2:0]         step_q;
  logic [2:0]         last_q;
  logic [FADDR_W-1:0] taddr_q;
  logic [FDATA_W-1:0] tdata_q;
  logic [FDATA_W-1:0] rd_q;
  logic               secure_q;
  logic               bypass_q;
  logic               refused_q;
  logic               error_q;
  logic [CNT_W-1:0]   win_q;
  logic               rb_m_q;
  logic               rb_s_q;
  logic               cyc_start;
  logic               cyc_done;
  logic [FADDR_W-1:0] cyc_addr;
  logic [FDATA_W-1:0] cyc_data;
  logic               cyc_write;
  logic [FDATA_W-1:0] cyc_rdata;
  logic               cmd_wr;
  logic [3:0]         new_op;
  logic               op_ok;

  // ------
  // ready/busy synchroniser
  // ------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rb_m_q <= 1'b1;
      rb_s_q <= 1'b1;
    end else if (ce_i) begin
      rb_m_q <= ready_busy_n_i;
      rb_s_q <= rb_m_q;
    end
  end

  // ------
  // command acceptance
  // ------
  assign cmd_wr = reg_we_i && (reg_addr_i == REG_CMD);
  assign new_op = reg_wdata_i[3:0];

  // legality of a new opcode against current mode and busy state
  always_comb begin
    op_ok = 1'b0;
    if (state_q == S_WIN) begin
      op_ok = 1'b1;  // R18
    end else if (state_q == S_IDLE && rb_s_q) begin  // R24 R6 R15 R21
      if (bypass_q) begin
        op_ok = (new_op == OP_PROGRAM) || (new_op == OP_BYP_EXIT) || (new_op == OP_READ);  // R10
      end else begin
        unique case (new_op)
          OP_BYP_ENTER: op_ok = !secure_q;  // R3
          OP_SEC_ENTER: op_ok = !secure_q;
          OP_SEC_EXIT:  op_ok = secure_q;
          OP_BYP_EXIT:  op_ok = 1'b0;
          OP_SECT_ADD:  op_ok = 1'b0;
          OP_PROGRAM, OP_CHIP_ER, OP_SECT_ER, OP_READ, OP_RESET: op_ok = 1'b1;
          default:      op_ok = 1'b0;
        endcase
      end
    end
  end

  // ------
  // sequence table: address/data of each step
  // ------
  // erase restarts its unlock pair at step 3, so parity alone is wrong
  always_comb begin
    cyc_addr  = (step_q == 3'd1 || step_q == 3'd4) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
    cyc_data  = (step_q == 3'd1 || step_q == 3'd4) ? UNLOCK_DATA2 : UNLOCK_DATA1;  // R12 R16
    cyc_write = 1'b1;
    if (step_q == last_q) begin
      cyc_addr = UNLOCK_ADDR1;
      unique case (op_q)
        OP_PROGRAM:   begin cyc_addr = taddr_q; cyc_data = tdata_q; end  // R4 R9
        OP_CHIP_ER:   cyc_data = CMD_CHIP_ER;  // R12
        OP_SECT_ER, OP_SECT_ADD: begin cyc_addr = taddr_q; cyc_data = CMD_SECT_ER; end  // R16
        OP_SEC_ENTER: cyc_data = CMD_SEC_IN;  // R1
        OP_SEC_EXIT:  cyc_data = CMD_SEC_OUT2;  // R1
        OP_BYP_ENTER: cyc_data = CMD_BYPASS;  // R8
        OP_BYP_EXIT:  cyc_data = CMD_BYP_RST2;  // R10
        OP_READ:      begin cyc_addr = taddr_q; cyc_write = 1'b0; end
        default:      cyc_data = CMD_RESET;  // R22
      endcase
    end else if (step_q == 3'd2 || (op_q == OP_PROGRAM && bypass_q) || op_q == OP_BYP_EXIT) begin
      unique case (op_q)
        OP_CHIP_ER, OP_SECT_ER: cyc_data = CMD_ERASE;
        OP_SEC_EXIT:            cyc_data = CMD_SEC_OUT;
        OP_BYP_EXIT:            cyc_data = CMD_BYP_RST;
        default:                cyc_data = CMD_PROGRAM;  // R4 R9
      endcase
    end
  end

  // ------
  // sequencer
  // ------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q   <= S_IDLE;
      op_q      <= 4'h0;
      step_q    <= 3'd0;
      last_q    <= 3'd0;
      cyc_start <= 1'b0;
      win_q     <= '0;
    end else if (ce_i) begin
      cyc_start <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (cmd_wr && op_ok) begin
            op_q      <= new_op;
            step_q    <= 3'd0;
            state_q   <= S_SEQ;
            cyc_start <= 1'b1;
            unique case (new_op)
              OP_PROGRAM:               last_q <= bypass_q ? 3'd1 : 3'd3;  // R4 R9 R11
              OP_CHIP_ER, OP_SECT_ER:   last_q <= 3'd5;  // R12 R16
              OP_SEC_ENTER, OP_BYP_ENTER: last_q <= 3'd2;  // R1 R8
              OP_SEC_EXIT:              last_q <= 3'd3;  // R1
              OP_BYP_EXIT:              last_q <= 3'd1;  // R10
              default:                  last_q <= 3'd0;  // R22
            endcase
          end
        end
        S_SEQ: begin
          if (cyc_done) begin
            if (step_q != last_q) begin
              step_q    <= step_q + 3'd1;
              cyc_start <= 1'b1;
            end else if (op_q == OP_SECT_ER || op_q == OP_SECT_ADD) begin
              state_q <= S_WIN;  // R19
              win_q   <= CNT_W'(WINDOW_CYC);
            end else if (op_q == OP_PROGRAM || op_q == OP_CHIP_ER) begin
              state_q <= S_WAIT;  // R5 R13
              win_q   <= CNT_W'(4);
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_WIN: begin
          if (cmd_wr && new_op == OP_SECT_ADD) begin
            op_q      <= OP_SECT_ADD;  // R17
            step_q    <= 3'd0;
            last_q    <= 3'd0;
            state_q   <= S_SEQ;
            cyc_start <= 1'b1;
          end else if (cmd_wr) begin
            state_q <= S_IDLE;  // R18
          end else if (win_q == '0) begin
            state_q <= S_WAIT;  // R21
            win_q   <= CNT_W'(4);
          end else begin
            win_q <= win_q - 1'b1;
          end
        end
        S_WAIT: begin
          // allow the device time to drop ready/busy through the synchroniser
          if (win_q != '0) begin
            win_q <= win_q - 1'b1;
          end else begin
            state_q <= S_POLL;
          end
        end
        S_POLL: begin
          if (rb_s_q) begin
            state_q <= S_IDLE;  // R14 R24
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ------
  // mode flags and read capture
  // ------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      secure_q  <= 1'b0;
      bypass_q  <= 1'b0;
      refused_q <= 1'b0;
      error_q   <= 1'b0;
      rd_q      <= 16'h0000;
    end else if (ce_i) begin
      if (cmd_wr && !op_ok) begin
        refused_q <= 1'b1;  // R2 R3
      end else if (cmd_wr) begin
        refused_q <= 1'b0;
      end
      if (state_q == S_SEQ && cyc_done && step_q == last_q) begin
        unique case (op_q)
          OP_SEC_ENTER: secure_q <= 1'b1;  // R1
          OP_SEC_EXIT:  secure_q <= 1'b0;  // R1
          OP_BYP_ENTER: bypass_q <= 1'b1;  // R8
          OP_BYP_EXIT:  bypass_q <= 1'b0;  // R10
          OP_READ: begin
            rd_q    <= cyc_rdata;
            error_q <= cyc_rdata[TIME_ERR_POS];  // R7
          end
          default: ;
        endcase
      end
    end
  end

  // ------
  // target registers, acceleration request, read port
  // ------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      taddr_q     <= '0;
      tdata_q     <= 16'h0000;
      accel_req_o <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (reg_we_i && reg_addr_i == REG_ADDR) begin
        taddr_q <= reg_wdata_i[FADDR_W-1:0];
      end
      if (reg_we_i && reg_addr_i == REG_WDATA) begin
        tdata_q <= reg_wdata_i[FDATA_W-1:0];
      end
      accel_req_o <= bypass_q && !secure_q && op_q == OP_PROGRAM && state_q != S_IDLE;  // R3 R11
      reg_rdata_o <= 32'h0000_0000;
      if (reg_re_i) begin
        unique case (reg_addr_i)
          REG_ADDR:   reg_rdata_o <= 32'(taddr_q);
          REG_WDATA:  reg_rdata_o <= 32'(tdata_q);
          REG_RDATA:  reg_rdata_o <= 32'(rd_q);
          REG_STATUS: reg_rdata_o <= 32'({error_q, state_q == S_WIN, refused_q, !rb_s_q,
                                          bypass_q, secure_q, state_q != S_IDLE});
          default:    reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // one bus cycle engine; R23 timing is kept inside
  flash_bus_cycle u_cycle (
    .clk_i            (clk_i),
    .srst_i           (srst_i),
    .ce_i             (ce_i),
    .start_i          (cyc_start),
    .write_i          (cyc_write),
    .addr_i           (cyc_addr),
    .data_i           (cyc_data),
    .done_o           (cyc_done),
    .rdata_o          (cyc_rdata),
    .dq_i             (dq_i),
    .dq_o             (dq_o),
    .dq_oe_o          (dq_oe_o),
    .addr_o           (addr_o),
    .flash_select_n_o (flash_select_n_o),
    .write_n_o        (write_n_o),
    .read_n_o         (read_n_o)
  );

endmodule
`default_nettype wire

// *** src/flash_host_pkg.sv ***
/*
  constants of the flash command host: codes, timing, register map.
  assumes a 10 MHz clock and a 16-bit flash data bus.
*/
package flash_host_pkg;

  // ------
  // clock and timing
  // ------
  localparam int CLK_NS              = 100;
  localparam int WINDOW_US           = 50;   // sector erase accumulation window
  // queued-sector gap, half the window kept as margin
  localparam int WINDOW_CYC          = (WINDOW_US * 1000 / CLK_NS) / 2;
  localparam int STROBE_NS           = 200;  // write strobe low time
  localparam int STROBE_CYC          = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_NS             = 300;  // read access allowance
  localparam int READ_CYC            = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W               = 12;

  // ------
  // flash bus
  // ------
  localparam int FADDR_W             = 23;
  localparam int FDATA_W             = 16;
  localparam logic [FADDR_W-1:0] UNLOCK_ADDR1 = 23'h000555;
  localparam logic [FADDR_W-1:0] UNLOCK_ADDR2 = 23'h0002aa;
  localparam logic [FDATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [FDATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [FDATA_W-1:0] CMD_PROGRAM  = 16'h00a0;
  localparam logic [FDATA_W-1:0] CMD_BYPASS   = 16'h0020;
  localparam logic [FDATA_W-1:0] CMD_ERASE    = 16'h0080;
  localparam logic [FDATA_W-1:0] CMD_CHIP_ER  = 16'h0010;
  localparam logic [FDATA_W-1:0] CMD_SECT_ER  = 16'h0030;
  localparam logic [FDATA_W-1:0] CMD_SEC_IN   = 16'h0088;
  localparam logic [FDATA_W-1:0] CMD_SEC_OUT  = 16'h0090;
  localparam logic [FDATA_W-1:0] CMD_SEC_OUT2 = 16'h0000;
  localparam logic [FDATA_W-1:0] CMD_BYP_RST  = 16'h0090;
  localparam logic [FDATA_W-1:0] CMD_BYP_RST2 = 16'h0000;
  localparam logic [FDATA_W-1:0] CMD_RESET    = 16'h00f0;

  // status bit positions in read data
  localparam int DATA_POLL_POS       = 7;
  localparam int TOGGLE_POS          = 6;
  localparam int TIME_ERR_POS        = 5;
  localparam int ERASE_WIN_POS       = 3;

  // ------
  // software register map (word index)
  // ------
  localparam int REG_AW              = 3;
  localparam logic [REG_AW-1:0] REG_CMD    = 3'h0;  // write: opcode starts a job
  localparam logic [REG_AW-1:0] REG_ADDR   = 3'h1;  // target address
  localparam logic [REG_AW-1:0] REG_WDATA  = 3'h2;  // program data
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h3;  // read: state flags
  localparam logic [REG_AW-1:0] REG_RDATA  = 3'h4;  // read: last flash read

  // opcodes written to REG_CMD
  localparam logic [3:0] OP_PROGRAM   = 4'h1;
  localparam logic [3:0] OP_CHIP_ER   = 4'h2;
  localparam logic [3:0] OP_SECT_ER   = 4'h3;  // first sector of a batch
  localparam logic [3:0] OP_SECT_ADD  = 4'h4;  // further sector in the window
  localparam logic [3:0] OP_SEC_ENTER = 4'h5;
  localparam logic [3:0] OP_SEC_EXIT  = 4'h6;
  localparam logic [3:0] OP_BYP_ENTER = 4'h7;
  localparam logic [3:0] OP_BYP_EXIT  = 4'h8;
  localparam logic [3:0] OP_READ      = 4'h9;
  localparam logic [3:0] OP_RESET     = 4'ha;

  // status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_SECURE  = 1;
  localparam int ST_BYPASS  = 2;
  localparam int ST_DEV_BSY = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_WIN_OPEN = 5;
  localparam int ST_ERROR   = 6;

endpackage
